// >>> rtl/ppm_pkg.sv
// Purpose: Shared constants and types for the port B pin override mux
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   Registers sit in the low byte lane
package ppm_pkg;

   //****************************************************************
   // Register map
   //****************************************************************
   localparam logic [7:0] PPM_OFS_PORT_OUT  = 8'h00;
   localparam logic [7:0] PPM_OFS_DIRECTION = 8'h04;
   localparam logic [7:0] PPM_OFS_PIN_READ  = 8'h08;
   localparam logic [7:0] PPM_OFS_MCU_CTRL  = 8'h0C;

   localparam logic [7:0] PPM_RST_PORT_OUT  = 8'h00;
   localparam logic [7:0] PPM_RST_DIRECTION = 8'h00;
   localparam logic [7:0] PPM_RST_MCU_CTRL  = 8'h00;

   // Control register fields
   localparam int PPM_BIT_SERIAL_PIN_SELECT  = 7;
   localparam int PPM_BIT_PULLUP_GLOBAL_OFF  = 4;
   localparam int PPM_BIT_VECTOR_TABLE_SEL   = 1;
   localparam int PPM_BIT_VECTOR_CHANGE_EN   = 0;
   localparam logic [7:0] PPM_MCU_CTRL_WMASK = 8'h93;

   // Port B pin roles
   localparam int PPM_PIN_SCK   = 7;
   localparam int PPM_PIN_ICP   = 6;
   localparam int PPM_PIN_IRQ2  = 5;
   localparam int PPM_PIN_IRQ1  = 2;
   localparam int PPM_PIN_MOSI  = 1;
   localparam int PPM_PIN_MISO  = 0;
   localparam int PPM_NUM_PINS  = 8;

   localparam logic [1:0] PPM_RESP_OKAY   = 2'h0;
   localparam logic [1:0] PPM_RESP_SLVERR = 2'h2;

   //****************************************************************
   // Types
   //****************************************************************
   // Override set offered by alternate functions for one pin
   typedef struct packed {
      logic pullup_override_en;
      logic pullup_override_val;
      logic drive_override_en;
      logic drive_override_val;
      logic level_override_en;
      logic level_override_val;
      logic output_toggle_override;
      logic input_gate_override_en;
      logic input_gate_override_val;
   } ppm_ovr_t;

   // Pad controls of one pin
   typedef struct packed {
      logic pad_out;
      logic pad_oe_n;
      logic pullup_en;
      logic input_en;
   } ppm_pad_t;

   // Whole state of the block
   typedef struct packed {
      logic [7:0]  pin_output_bit;
      logic [7:0]  pin_direction_bit;
      logic [7:0]  mcu_control_reg;
      logic [7:0]  sync_first;
      logic [7:0]  sync_second;
      logic        aw_held;
      logic [7:0]  aw_addr;
      logic        w_held;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } ppm_state_t;

endpackage

// >>> rtl/ppm_port_mux.sv
// Purpose: Port B pin control with alternate-function overrides
// Assumes: One clock (aclk, the I/O clock); pad inputs are asynchronous
// Notes:   Override selection is combinational; registers over AXI4-Lite
//
// Summary of operation
// RULE_01: Default pull-up only when dir 0, out 1, global-off 0
// RULE_02: Pull-up override enable selects override value
// RULE_03: Drive override enable selects driver enable source
// RULE_04: Overridden driver follows drive override value
// RULE_05: Driven level from level override or output bit
// RULE_06: Level override value replaces output register bit
// RULE_07: Toggle override inverts the output register bit
// RULE_08: Input gate override or sleep state sets input enable
// RULE_09: Overridden input enable follows override value
// RULE_10: Raw input tapped before the read synchronizer
// RULE_11: Consumers synchronize raw input unless used as clock
// RULE_12: Analog link connects straight to pad
// RULE_13: Strobes per port; clock, sleep, pull-off global
// RULE_14: Control bit 4 disables all port pull-ups
// RULE_15: SPI slave forces pin 7 to input
// RULE_16: SPI master leaves pin 7 direction to register
// RULE_17: Forced pin 7 pull-up follows its output bit
// RULE_18: Pin 6 feeds timer 1 alternate capture input
// RULE_19: Pins 1/0 carry MOSI/MISO and stage 2 outputs
// RULE_20: Pins 5/2 carry external irq 2/1 and ADC
// RULE_21: Sleep clamps digital input unless override enabled
// RULE_22: Override selection is combinational, same cycle
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps

module ppm_port_mux
   import ppm_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Pads
   input  wire logic [7:0]  pad_in,
   output logic [7:0]       pad_out,
   output logic [7:0]       pad_oe_n,
   output logic [7:0]       pad_pullup_en,
   output logic [7:0]       analog_pad_link,
   // Global sleep clamp from the sleep controller
   input  wire logic        sleep_clamp,
   // Peripheral side
   input  wire logic        spi_enable,
   input  wire logic        spi_master,
   input  wire logic        spi_sck_out,
   input  wire logic        spi_mosi_out,
   input  wire logic        spi_miso_out,
   input  wire logic        stage0_out1,
   input  wire logic        stage0_out1_en,
   input  wire logic        stage1_out1,
   input  wire logic        stage1_out1_en,
   input  wire logic        stage2_out1,
   input  wire logic        stage2_out1_en,
   input  wire logic        stage2_out0,
   input  wire logic        stage2_out0_en,
   input  wire logic [7:0]  adc_digital_off,
   input  wire logic        ext_irq_1_en,
   input  wire logic        ext_irq_2_en,
   input  wire logic [7:0]  output_toggle_override,
   output logic [7:0]       alt_function_raw_input,
   output logic             spi_sck_in,
   output logic             spi_mosi_in,
   output logic             spi_miso_in,
   output logic             timer1_capture_alt_in,
   output logic             ext_irq_1,
   output logic             ext_irq_2,
   output logic             vector_table_select,
   output logic             vector_change_enable
);

   //****************************************************************
   // Declarations
   //****************************************************************
   ppm_state_t         st;
   ppm_state_t         next_st;
   ppm_ovr_t   [7:0]   ovr;
   ppm_pad_t   [7:0]   pad;
   logic               serial_pin_select;
   logic               pullup_global_off;
   logic               spi_on_port;
   logic               spi_slave;
   logic               spi_mst;
   logic       [7:0]   raw_di;
   logic       [7:0]   wr_byte;
   logic               wr_fire;
   logic       [7:0]   rd_byte;
   logic               rd_hit;

   assign serial_pin_select = st.mcu_control_reg[PPM_BIT_SERIAL_PIN_SELECT];
   assign pullup_global_off = st.mcu_control_reg[PPM_BIT_PULLUP_GLOBAL_OFF];
   assign spi_on_port       = spi_enable & ~serial_pin_select;
   assign spi_slave         = spi_on_port & ~spi_master;
   assign spi_mst           = spi_on_port & spi_master;

   //****************************************************************
   // Port B alternate-function override sources
   //****************************************************************
   // Overrides gathered per pin from the peripherals
   always_comb begin
      ovr = '0;
      // Pin 7: SPI clock and stage 0 output 1
      // Slave forces input, pull-up still follows the output bit
      ovr[PPM_PIN_SCK].pullup_override_en  = spi_slave; // [RULE_17]
      ovr[PPM_PIN_SCK].pullup_override_val = st.pin_output_bit[PPM_PIN_SCK]
                                             & ~pullup_global_off; // [RULE_17]
      ovr[PPM_PIN_SCK].drive_override_en   = spi_slave | stage0_out1_en; // [RULE_15] [RULE_16]
      ovr[PPM_PIN_SCK].drive_override_val  = stage0_out1_en; // [RULE_15]
      ovr[PPM_PIN_SCK].level_override_en   = spi_mst | stage0_out1_en;
      ovr[PPM_PIN_SCK].level_override_val  = stage0_out1_en ? stage0_out1 : spi_sck_out;
      // Pin 6: stage 1 output 1
      ovr[PPM_PIN_ICP].drive_override_en   = stage1_out1_en;
      ovr[PPM_PIN_ICP].drive_override_val  = 1'b1;
      ovr[PPM_PIN_ICP].level_override_en   = stage1_out1_en;
      ovr[PPM_PIN_ICP].level_override_val  = stage1_out1;
      // Pins 5, 2: irq enables keep input alive in sleep
      ovr[PPM_PIN_IRQ2].input_gate_override_en  = adc_digital_off[PPM_PIN_IRQ2] | ext_irq_2_en; // [RULE_20]
      ovr[PPM_PIN_IRQ2].input_gate_override_val = ext_irq_2_en;                                  // [RULE_20]
      ovr[PPM_PIN_IRQ1].input_gate_override_en  = adc_digital_off[PPM_PIN_IRQ1] | ext_irq_1_en; // [RULE_20]
      ovr[PPM_PIN_IRQ1].input_gate_override_val = ext_irq_1_en;                                  // [RULE_20]
      // Pins 7, 6, 4, 3: analog use gates off input
      ovr[7].input_gate_override_en = adc_digital_off[7];
      ovr[6].input_gate_override_en = adc_digital_off[6];
      ovr[4].input_gate_override_en = adc_digital_off[4];
      ovr[3].input_gate_override_en = adc_digital_off[3];
      // Pin 1: MOSI, stage 2 output 1
      ovr[PPM_PIN_MOSI].pullup_override_en  = spi_slave; // [RULE_19]
      ovr[PPM_PIN_MOSI].pullup_override_val = st.pin_output_bit[PPM_PIN_MOSI] & ~pullup_global_off;
      ovr[PPM_PIN_MOSI].drive_override_en   = spi_slave | stage2_out1_en; // [RULE_19]
      ovr[PPM_PIN_MOSI].drive_override_val  = stage2_out1_en;
      ovr[PPM_PIN_MOSI].level_override_en   = spi_mst | stage2_out1_en;
      ovr[PPM_PIN_MOSI].level_override_val  = stage2_out1_en ? stage2_out1 : spi_mosi_out;
      // Pin 0: MISO, stage 2 output 0
      ovr[PPM_PIN_MISO].pullup_override_en  = spi_mst; // [RULE_19]
      ovr[PPM_PIN_MISO].pullup_override_val = st.pin_output_bit[PPM_PIN_MISO] & ~pullup_global_off;
      ovr[PPM_PIN_MISO].drive_override_en   = spi_mst | stage2_out0_en; // [RULE_19]
      ovr[PPM_PIN_MISO].drive_override_val  = stage2_out0_en;
      ovr[PPM_PIN_MISO].level_override_en   = spi_slave | stage2_out0_en;
      ovr[PPM_PIN_MISO].level_override_val  = stage2_out0_en ? stage2_out0 : spi_miso_out;
      // Toggle requests from alternate functions, one per pin
      for (int i = 0; i < PPM_NUM_PINS; i++) begin
         ovr[i].output_toggle_override = output_toggle_override[i];
      end
   end

   //****************************************************************
   // Generic per-pin override mux (combinational)
   //****************************************************************
   // Same-cycle path from every override except the toggle (registered) to the pad controls [RULE_22]
   always_comb begin
      for (int i = 0; i < PPM_NUM_PINS; i++) begin
         // Pull-up: override, else {dir, out, global off} == 010
         if (ovr[i].pullup_override_en) begin
            pad[i].pullup_en = ovr[i].pullup_override_val; // [RULE_02]
         end else begin
            pad[i].pullup_en = ~st.pin_direction_bit[i] & st.pin_output_bit[i]
                               & ~pullup_global_off; // [RULE_01] [RULE_14]
         end
         // Driver enable: override value or direction bit
         if (ovr[i].drive_override_en) begin
            pad[i].pad_oe_n = ~ovr[i].drive_override_val; // [RULE_03] [RULE_04]
         end else begin
            pad[i].pad_oe_n = ~st.pin_direction_bit[i]; // [RULE_03]
         end
         // Driven level: override value or output bit
         if (ovr[i].level_override_en) begin
            pad[i].pad_out = ovr[i].level_override_val; // [RULE_05] [RULE_06]
         end else begin
            pad[i].pad_out = st.pin_output_bit[i]; // [RULE_05]
         end
         // Digital input enable: override or sleep clamp
         if (ovr[i].input_gate_override_en) begin
            pad[i].input_en = ovr[i].input_gate_override_val; // [RULE_08] [RULE_09]
         end else begin
            pad[i].input_en = ~sleep_clamp; // [RULE_08] [RULE_21]
         end
         // Raw input after the input gate, ahead of the synchronizer
         raw_di[i] = pad_in[i] & pad[i].input_en; // [RULE_10]
      end
   end

   //****************************************************************
   // Pad and peripheral outputs
   //****************************************************************
   always_comb begin
      for (int i = 0; i < PPM_NUM_PINS; i++) begin
         pad_out[i]       = pad[i].pad_out;
         pad_oe_n[i]      = pad[i].pad_oe_n;
         pad_pullup_en[i] = pad[i].pullup_en;
      end
   end

   // Analog path ties straight to the pad node, no gating [RULE_12]
   assign analog_pad_link        = pad_in;
   // Unsynchronized taps; consumers synchronize unless used as clock [RULE_11]
   assign alt_function_raw_input = raw_di; // [RULE_10]
   assign spi_sck_in             = raw_di[PPM_PIN_SCK] & spi_on_port;
   assign spi_mosi_in            = raw_di[PPM_PIN_MOSI] & spi_on_port; // [RULE_19]
   assign spi_miso_in            = raw_di[PPM_PIN_MISO] & spi_on_port; // [RULE_19]
   assign timer1_capture_alt_in  = raw_di[PPM_PIN_ICP]; // [RULE_18]
   assign ext_irq_2              = raw_di[PPM_PIN_IRQ2]; // [RULE_20]
   assign ext_irq_1              = raw_di[PPM_PIN_IRQ1]; // [RULE_20]
   assign vector_table_select    = st.mcu_control_reg[PPM_BIT_VECTOR_TABLE_SEL];
   assign vector_change_enable   = st.mcu_control_reg[PPM_BIT_VECTOR_CHANGE_EN];

   //****************************************************************
   // AXI4-Lite handshakes
   //****************************************************************
   // Address and data held apart; write fires once both are in
   assign s_axi_awready = ~st.aw_held & ~st.bvalid;
   assign s_axi_wready  = ~st.w_held & ~st.bvalid;
   assign s_axi_arready = ~st.rvalid;
   assign s_axi_bvalid  = st.bvalid;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_rvalid  = st.rvalid;
   assign s_axi_rdata   = st.rdata;
   assign s_axi_rresp   = st.rresp;

   assign wr_fire = st.aw_held & st.w_held & ~st.bvalid;
   assign wr_byte = st.w_data[7:0];

   // Read decode; one shared strobe set for the whole port [RULE_13]
   always_comb begin
      rd_hit  = 1'b1;
      rd_byte = 8'h00;
      case (s_axi_araddr)
         PPM_OFS_PORT_OUT:  rd_byte = st.pin_output_bit;
         PPM_OFS_DIRECTION: rd_byte = st.pin_direction_bit;
         PPM_OFS_PIN_READ:  rd_byte = st.sync_second;
         PPM_OFS_MCU_CTRL:  rd_byte = st.mcu_control_reg;
         default:           rd_hit  = 1'b0;
      endcase
   end

   //****************************************************************
   // Next-state logic
   //****************************************************************
   always_comb begin
      next_st = st;
      // Two-stage read synchronizer on the gated raw input
      next_st.sync_first  = raw_di;
      next_st.sync_second = st.sync_first;
      // Capture write address and data in either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_st.w_held = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
      end
      // Alternate-function toggles invert the output bits [RULE_07]
      next_st.pin_output_bit = st.pin_output_bit ^ output_toggle_override; // [RULE_07]
      // Register write once both halves are held
      if (wr_fire) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = PPM_RESP_OKAY;
         case (st.aw_addr)
            PPM_OFS_PORT_OUT: begin
               if (st.w_strb[0]) begin
                  next_st.pin_output_bit = wr_byte ^ output_toggle_override;
               end
            end
            PPM_OFS_DIRECTION: begin
               if (st.w_strb[0]) begin
                  next_st.pin_direction_bit = wr_byte;
               end
            end
            PPM_OFS_PIN_READ: begin
               // Writing ones to the pin register toggles the output bits
               if (st.w_strb[0]) begin
                  next_st.pin_output_bit = st.pin_output_bit ^ output_toggle_override ^ wr_byte;
               end
            end
            PPM_OFS_MCU_CTRL: begin
               if (st.w_strb[0]) begin
                  next_st.mcu_control_reg = wr_byte & PPM_MCU_CTRL_WMASK; // [RULE_14]
               end
            end
            default: begin
               next_st.bresp = PPM_RESP_SLVERR;
            end
         endcase
      end
      // Write response retires on bready
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      // Read answer one cycle after address taken
      if (s_axi_arvalid && s_axi_arready) begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = {24'h000000, rd_byte};
         next_st.rresp  = rd_hit ? PPM_RESP_OKAY : PPM_RESP_SLVERR;
      end else if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
   end

   //****************************************************************
   // State register
   //****************************************************************
   // Synchronous active-low reset puts every pin in tri-state input
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st                   <= '0;
         st.pin_output_bit    <= PPM_RST_PORT_OUT;
         st.pin_direction_bit <= PPM_RST_DIRECTION;
         st.mcu_control_reg   <= PPM_RST_MCU_CTRL;
      end else begin
         st <= next_st;
      end
   end

endmodule

// >>> tb/ppm_periph_model.sv
// Purpose: Alternate-function peripherals that drive the port B overrides
// Assumes: One clock; the bench picks SPI mode and power stage outputs
// Notes:   The raw pin input is resynchronised here before any use
`timescale 1ns/10ps
module ppm_periph_model
   import ppm_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic [1:0] spi_mode,
   input  wire logic [3:0] stage_en,
   input  wire logic [3:0] stage_val,
   input  wire logic [7:0] raw_in,
   output logic            spi_enable,
   output logic            spi_master,
   output logic [3:0]      stage_out,
   output logic [3:0]      stage_out_en,
   output logic [7:0]      raw_sync
);
   logic [7:0] sync_a;
   // SPI off (0), slave (1) or master (2)
   assign spi_enable   = |spi_mode;
   assign spi_master   = spi_mode[1];
   // Stage outputs low while disabled
   assign stage_out_en = stage_en;
   assign stage_out    = stage_val & stage_en;
   // Own two-flop synchronizer, since the raw input is asynchronous
   always_ff @(posedge aclk) begin
      sync_a   <= raw_in;
      raw_sync <= sync_a;
   end
endmodule

// >>> tb/ppm_checker.sv
// Purpose: Port-level checks of the pin override mux
// Assumes: One clock; reset is synchronous, active low
// Notes:   Bound to the top module, sees only its ports
`timescale 1ns/10ps
module ppm_checker
   import ppm_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [7:0] pad_in,
   input  wire logic [7:0] pad_out,
   input  wire logic [7:0] pad_oe_n,
   input  wire logic [7:0] analog_pad_link,
   input  wire logic [7:0] alt_function_raw_input,
   input  wire logic [7:0] adc_digital_off,
   input  wire logic [7:0] output_toggle_override,
   input  wire logic       sleep_clamp,
   input  wire logic       stage1_out1,
   input  wire logic       stage1_out1_en,
   input  wire logic       s_axi_wvalid,
   input  wire logic       timer1_capture_alt_in,
   input  wire logic       ext_irq_1,
   input  wire logic       ext_irq_2
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_link; analog_pad_link == pad_in; endproperty
   a_link: assert property (p_link) else $error("analog link differs from pad");
   property p_raw; (alt_function_raw_input & ~pad_in) == 8'h00; endproperty
   a_raw: assert property (p_raw) else $error("raw input not taken from pad");
   property p_taps; timer1_capture_alt_in == alt_function_raw_input[6] && ext_irq_2 == alt_function_raw_input[5]
      && ext_irq_1 == alt_function_raw_input[2]; endproperty
   a_taps: assert property (p_taps) else $error("capture or irq tap wrong");
   property p_sleep; sleep_clamp && !adc_digital_off[3] |-> !alt_function_raw_input[3]; endproperty
   a_sleep: assert property (p_sleep) else $error("sleep did not clamp input");
   property p_awake; !sleep_clamp && !adc_digital_off[4] |-> alt_function_raw_input[4] == pad_in[4]; endproperty
   a_awake: assert property (p_awake) else $error("input gated while awake");
   property p_gate; adc_digital_off[7] |-> !alt_function_raw_input[7]; endproperty
   a_gate: assert property (p_gate) else $error("input gate override ignored");
   property p_stage; stage1_out1_en |-> !pad_oe_n[6] && pad_out[6] == stage1_out1; endproperty
   a_stage: assert property (p_stage) else $error("stage override not applied");
   property p_tog; output_toggle_override[2] && !pad_oe_n[2] && !s_axi_wvalid && !$past(s_axi_wvalid)
      |=> !pad_oe_n[2] && pad_out[2] != $past(pad_out[2]); endproperty
   a_tog: assert property (p_tog) else $error("toggle did not invert output");
endmodule
bind ppm_port_mux ppm_checker u_chk (.aclk(aclk), .aresetn(aresetn), .pad_in(pad_in), .pad_out(pad_out),
   .pad_oe_n(pad_oe_n), .analog_pad_link(analog_pad_link), .alt_function_raw_input(alt_function_raw_input),
   .adc_digital_off(adc_digital_off), .output_toggle_override(output_toggle_override), .sleep_clamp(sleep_clamp),
   .stage1_out1(stage1_out1), .stage1_out1_en(stage1_out1_en), .s_axi_wvalid(s_axi_wvalid),
   .timer1_capture_alt_in(timer1_capture_alt_in), .ext_irq_1(ext_irq_1), .ext_irq_2(ext_irq_2));

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the pin override mux
// Assumes: 40 MHz clock; bus tasks wait for each answer
// Notes:   Pads compared at the falling edge
`timescale 1ns/10ps
module tb_top;
   import ppm_pkg::*;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sleep, sck, mosi;
   logic        awready, wready, bvalid, arready, rvalid, spi_en, spi_ms, icp, irq1, irq2;
   logic [2:0]  sin;
   logic [7:0]  awaddr, araddr, pad_in, adc_off, tog, pout, poe_n, pup, alink, raw, raw_s;
   logic [31:0] wdata, rdata;
   logic [1:0]  spi_mode, irq_en, bresp, rresp, vts;
   logic [3:0]  st_en, st_val, st_o, st_oe;
   int          err_total = 0, n_checks = 0, cyc = 0;
   ppm_port_mux DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pad_in(pad_in), .pad_out(pout), .pad_oe_n(poe_n),
      .pad_pullup_en(pup), .analog_pad_link(alink), .sleep_clamp(sleep), .spi_enable(spi_en), .spi_master(spi_ms),
      .spi_sck_out(sck), .spi_mosi_out(mosi), .spi_miso_out(sck), .stage0_out1(st_o[0]), .stage0_out1_en(st_oe[0]),
      .stage1_out1(st_o[1]), .stage1_out1_en(st_oe[1]), .stage2_out1(st_o[2]), .stage2_out1_en(st_oe[2]),
      .stage2_out0(st_o[3]), .stage2_out0_en(st_oe[3]), .adc_digital_off(adc_off), .ext_irq_1_en(irq_en[0]),
      .ext_irq_2_en(irq_en[1]), .output_toggle_override(tog), .alt_function_raw_input(raw), .spi_sck_in(sin[2]),
      .spi_mosi_in(sin[1]), .spi_miso_in(sin[0]), .timer1_capture_alt_in(icp), .ext_irq_1(irq1), .ext_irq_2(irq2),
      .vector_table_select(vts[1]), .vector_change_enable(vts[0]));
   ppm_periph_model u_periph (.aclk(aclk), .spi_mode(spi_mode), .stage_en(st_en), .stage_val(st_val),
      .raw_in(raw), .spi_enable(spi_en), .spi_master(spi_ms), .stage_out(st_o), .stage_out_en(st_oe), .raw_sync(raw_s));
   // Clock and hang guard
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_total++;
         report_and_stop();
      end
   end
   task automatic check(input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Bus write: address and data offered together, each released when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      check(bresp, er);
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      check(rdata, exp);
      check(rresp, er);
   endtask
   // Main sequence
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, sleep, sck, mosi} = '0;
      {awaddr, araddr, adc_off, tog, wdata, spi_mode, irq_en, st_en, st_val} = '0;
      pad_in = 8'hE5;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      check(poe_n, 8'hFF);
      check(pup, 8'h00);
      axi_rd(PPM_OFS_MCU_CTRL, 32'h00, PPM_RESP_OKAY);
      axi_wr(PPM_OFS_PORT_OUT, 32'hC3, PPM_RESP_OKAY);
      axi_wr(PPM_OFS_DIRECTION, 32'h0F, PPM_RESP_OKAY);
      @(negedge aclk);
      check(poe_n, 8'hF0);
      check(pup, 8'hC0);
      check(pout & 8'h0F, 8'h03);
      axi_wr(PPM_OFS_MCU_CTRL, 32'h10, PPM_RESP_OKAY);
      @(negedge aclk);
      check(pup, 8'h00);
      axi_wr(PPM_OFS_MCU_CTRL, 32'hFF, PPM_RESP_OKAY);
      axi_rd(PPM_OFS_MCU_CTRL, 32'h93, PPM_RESP_OKAY);
      check(vts, 2'b11);
      axi_wr(PPM_OFS_MCU_CTRL, 32'h00, PPM_RESP_OKAY);
      axi_wr(8'h10, 32'hFF, PPM_RESP_SLVERR);
      axi_rd(8'h10, 32'h00, PPM_RESP_SLVERR);
      // Toggle pin 2 for one cycle, then pin 0 via the pin register
      @(posedge aclk);
      tog <= 8'h04;
      @(posedge aclk);
      tog <= 8'h00;
      axi_rd(PPM_OFS_PORT_OUT, 32'hC7, PPM_RESP_OKAY);
      axi_wr(PPM_OFS_PIN_READ, 32'h01, PPM_RESP_OKAY);
      axi_rd(PPM_OFS_PORT_OUT, 32'hC6, PPM_RESP_OKAY);
      axi_rd(PPM_OFS_PIN_READ, 32'hE5, PPM_RESP_OKAY);
      check(alink, 8'hE5);
      // Sleep clamps all but the irq pin
      @(posedge aclk);
      sleep  <= 1'b1;
      irq_en <= 2'b10;
      @(negedge aclk);
      check(raw, 8'h20);
      check(irq2, 1'b1);
      @(posedge aclk);
      sleep   <= 1'b0;
      adc_off <= 8'h80;
      @(negedge aclk);
      check(raw, 8'h65);
      check({icp, irq1}, 2'b11);
      // Stage 1 takes pin 6 in the same cycle
      @(posedge aclk);
      st_en  <= 4'h2;
      st_val <= 4'h2;
      @(negedge aclk);
      check({poe_n[6], pout[6]}, 2'b01);
      @(posedge aclk);
      st_val <= 4'h0;
      @(negedge aclk);
      check(pout[6], 1'b0);
      check(raw_s, 8'h65);
      // SPI slave then master on pins 7, 1 and 0
      @(posedge aclk);
      st_en    <= 4'h0;
      spi_mode <= 2'd1;
      axi_wr(PPM_OFS_DIRECTION, 32'h8F, PPM_RESP_OKAY);
      @(negedge aclk);
      check(poe_n & 8'h82, 8'h82);
      check(pup[7], 1'b1);
      @(posedge aclk);
      spi_mode <= 2'd2;
      sck      <= 1'b1;
      @(negedge aclk);
      check(poe_n & 8'h83, 8'h01);
      check(pout & 8'h82, 8'h80);
      check(sin, 3'b001);
      @(posedge aclk);
      st_en  <= 4'h4;
      st_val <= 4'h4;
      @(negedge aclk);
      check(pout[1], 1'b1);
      report_and_stop();
   end
endmodule
